/* File: dv/accel_modulator_model.sv */
// modulator model: one-bit samples with a strobe
`timescale 1ns/1ns
module accel_modulator_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic bit_in,
    input wire logic [3:0] gap,
    output logic sd_bit,
    output logic sd_strobe
);
    // ==================================================================
    // strobe pacing
    int cnt = 0; // cycles since last strobe
    initial begin
        sd_bit = 1'b0;
        sd_strobe = 1'b0;
    end
    // one strobe every gap cycles, changed at the falling edge
    always @(negedge mclk) begin
        if (!rst_n) begin
            cnt = 0;
            sd_strobe <= 1'b0;
        end else if (cnt + 1 >= int'(gap)) begin
            cnt = 0;
            sd_strobe <= 1'b1;
            sd_bit <= bit_in;
        end else begin
            // bit line not valid here: keep it moving
            cnt = cnt + 1;
            sd_strobe <= 1'b0;
            sd_bit <= ~sd_bit;
        end
    end
endmodule : accel_modulator_model

/* File: dv/accel_offset_props.sv */
// port assertions of the decimation and offset path
`timescale 1ns/1ns
module accel_offset_props #(
    parameter int PH1_CYCLES = 200,
    parameter int PH2_CYCLES = 150,
    parameter int RATE_CYCLES = 20
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SD_STROBE,
    input wire logic SECOND_SELFTEST_STEP,
    input wire logic signed [25:0] ACCEL_OUT,
    input wire logic ACCEL_VALID,
    input wire logic signed [25:0] OFFSET_OUT,
    input wire logic OFFSET_INIT_DONE_N
);
    // ==================================================================
    // helper counters
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    logic [3:0] str_reg; // strobes in current block
    logic [31:0] cyc_reg; // edges since release
    logic [31:0] gap_reg; // cycles since last limited step
    logic signed [25:0] prev_off_reg; // offset one cycle back
    wire sixteenth = SD_STROBE && (str_reg == 4'hF);
    wire init_over = cyc_reg >= 32'(PH1_CYCLES + PH2_CYCLES);
    wire off_moved = OFFSET_OUT != prev_off_reg;
    wire [31:0] gap_next = OFFSET_INIT_DONE_N ? 32'(RATE_CYCLES) :
        off_moved ? 32'h0 :
        (gap_reg < 32'(RATE_CYCLES)) ? gap_reg + 32'h1 : gap_reg;
    // counters restart with every reset
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            str_reg <= 4'h0;
            cyc_reg <= 32'h0;
            gap_reg <= 32'(RATE_CYCLES);
            prev_off_reg <= 26'sh0;
        end else begin
            str_reg <= str_reg + 4'(SD_STROBE);
            cyc_reg <= cyc_reg + 32'h1;
            gap_reg <= gap_next;
            prev_off_reg <= OFFSET_OUT;
        end
    end
    // ==================================================================
    // properties
    property p_valid_latency;
        sixteenth |-> ##5 ACCEL_VALID;
    endproperty
    a_valid_latency: assert property (p_valid_latency)
        else $error("sample missing after block end");
    property p_valid_gap;
        ACCEL_VALID |=> !ACCEL_VALID [*8];
    endproperty
    a_valid_gap: assert property (p_valid_gap)
        else $error("samples too close");
    property p_accel_hold;
        $changed(ACCEL_OUT) |-> ACCEL_VALID;
    endproperty
    a_accel_hold: assert property (p_accel_hold)
        else $error("output moved without valid");
    property p_done_early;
        !init_over |-> OFFSET_INIT_DONE_N;
    endproperty
    a_done_early: assert property (p_done_early)
        else $error("init done too early");
    property p_done_sticky;
        !OFFSET_INIT_DONE_N |=> !OFFSET_INIT_DONE_N;
    endproperty
    a_done_sticky: assert property (p_done_sticky)
        else $error("init done flag returned");
    property p_first_edge;
        $rose(RST_N) |-> OFFSET_INIT_DONE_N && !ACCEL_VALID &&
            (OFFSET_OUT == 26'sh0);
    endproperty
    a_first_edge: assert property (p_first_edge)
        else $error("not restarted after reset");
    property p_freeze;
        SECOND_SELFTEST_STEP && OFFSET_INIT_DONE_N |=> $stable(OFFSET_OUT);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("offset moved while frozen");
    property p_step;
        !OFFSET_INIT_DONE_N && !$past(OFFSET_INIT_DONE_N) |->
            (OFFSET_OUT - $past(OFFSET_OUT)) inside {-26'sh1, 26'sh0, 26'sh1};
    endproperty
    a_step: assert property (p_step)
        else $error("offset step too large");
    property p_interval;
        !OFFSET_INIT_DONE_N && !$past(OFFSET_INIT_DONE_N) && off_moved
            |-> gap_reg >= 32'(RATE_CYCLES - 1);
    endproperty
    a_interval: assert property (p_interval)
        else $error("offset steps too frequent");
endmodule : accel_offset_props
bind accel_decimation_offset_cancel accel_offset_props #(
    .PH1_CYCLES(PH1_CYCLES), .PH2_CYCLES(PH2_CYCLES),
    .RATE_CYCLES(RATE_CYCLES)) i_accel_offset_props (.MCLK(MCLK),
    .RST_N(RST_N), .SD_STROBE(SD_STROBE),
    .SECOND_SELFTEST_STEP(SECOND_SELFTEST_STEP), .ACCEL_OUT(ACCEL_OUT),
    .ACCEL_VALID(ACCEL_VALID), .OFFSET_OUT(OFFSET_OUT),
    .OFFSET_INIT_DONE_N(OFFSET_INIT_DONE_N));

/* File: dv/testbench.sv */
// self-checking bench of the decimation and offset path
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    import accel_dsp_pkg::*;
    // ==================================================================
    // stimulus and observation
    localparam int P1 = 1000; // shortened fast phase, long enough to settle
    localparam int P2 = 150; // shortened mid phase
    localparam int PS = 100; // shortened self-test sequence
    localparam int PR = 20; // shortened rate interval
    logic mclk = 1'b0, rst_n = 1'b0, bit_in = 1'b0, bias = 1'b1;
    logic st_run = 1'b0, st_step2 = 1'b0, sel = 1'b0;
    logic [3:0] gap = 4'h2; // strobe spacing
    logic sd_bit, sd_strobe, accel_valid, done_n;
    logic signed [25:0] accel_out, offset_out, snap;
    logic [31:0] lfsr = 32'h0001_42B0; // seed
    int n_mismatch = 0, checks = 0, cyc = 0, nstr = 0, want, d;
    int exp_q[$]; // expected sample edges
    accel_modulator_model i_accel_modulator_model (.mclk(mclk),
        .rst_n(rst_n), .bit_in(bit_in), .gap(gap), .sd_bit(sd_bit),
        .sd_strobe(sd_strobe));
    accel_decimation_offset_cancel #(.PH1_CYCLES(P1), .PH2_CYCLES(P2),
        .ST_CYCLES(PS), .RATE_CYCLES(PR)) i_accel_decimation_offset_cancel (
        .MCLK(mclk), .RST_N(rst_n), .SD_BIT(sd_bit), .SD_STROBE(sd_strobe),
        .SELFTEST_RUN(st_run), .SECOND_SELFTEST_STEP(st_step2),
        .NORMAL_OFFSET_FILTER_SELECT(sel), .ACCEL_OUT(accel_out),
        .ACCEL_VALID(accel_valid), .OFFSET_OUT(offset_out),
        .OFFSET_INIT_DONE_N(done_n));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic wait_to(input int n);
        while (cyc < n) @(negedge mclk);
    endtask : wait_to
    task automatic do_reset();
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (20) @(negedge mclk);
        `CHK(done_n, 1'b1)
        `CHK(offset_out, 26'sh0)
        `CHK(accel_out, 26'sh0)
        `CHK(accel_valid, 1'b0)
        rst_n = 1'b1;
    endtask : do_reset
    // ==================================================================
    // clock, random bits, watchdog
    initial forever #10 mclk = ~mclk;
    always @(negedge mclk) begin
        lfsr = lfsr_next(lfsr);
        bit_in <= bias | lfsr[0];
    end
    initial begin
        repeat (6000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end
    // edge count and model of sample timing
    always @(posedge mclk) begin
        if (!rst_n) begin
            cyc = 0;
            nstr = 0;
            exp_q.delete();
        end else begin
            cyc = cyc + 1;
            if (sd_strobe) begin
                nstr = (nstr + 1) % 16;
                if (nstr == 0) exp_q.push_back(cyc + 5);
            end
            if (accel_valid !== 1'b0) begin
                want = (exp_q.size() > 0) ? exp_q.pop_front() : -1;
                `CHK(want, cyc)
            end
        end
    end
    // ==================================================================
    // main sequence
    initial begin
        do_reset();
        // freeze by second step during mid phase
        wait_to(P1 + 10);
        snap = offset_out;
        st_step2 = 1'b1;
        wait_to(P1 + 40);
        `CHK(offset_out, snap)
        st_step2 = 1'b0;
        wait_to(P1 + P2 - 1);
        `CHK(offset_out > 26'sh0, 1'b1)
        `CHK(accel_out > 26'sh0, 1'b1)
        `CHK(done_n, 1'b1)
        wait_to(P1 + P2);
        `CHK(done_n, 1'b0)
        // normal operation, both filter selections, random input
        bias = 1'b0;
        for (int i = 0; i < 2; i++) begin
            sel = i[0];
            snap = offset_out;
            wait_to(cyc + 10 * PR);
            d = int'(offset_out) - int'(snap);
            `CHK((d <= 10) && (d >= -10), 1'b1)
        end
        // reset in mid-run, self-test held on, back-to-back strobes
        gap = 4'h1;
        st_run = 1'b1;
        do_reset();
        wait_to(P1 + P2 + 2);
        snap = offset_out;
        wait_to(P1 + P2 + 6 * PS - 1);
        `CHK(offset_out, snap)
        `CHK(done_n, 1'b1)
        wait_to(P1 + P2 + 6 * PS);
        `CHK(done_n, 1'b0)
        st_run = 1'b0;
        conclude();
    end
endmodule : testbench

/* File: hw/accel_decimation_offset_cancel.sv */
// decimation, low-pass and offset cancellation of the acceleration path
`timescale 1ns/1ns
// How it works
// - one-bit sample per 1 MHz strobe
// - third-order sinc decimates sixteen to one
// - two IIR sections, overall gain applied
// - offset low-pass, three selectable coefficient sets
// - 10 Hz 80 ms, 0.3 Hz 70 ms
// - self-test keeps 0.3 Hz, 96 ms repeats
// - offset output frozen during self-test
// - normal set by select bit, limiting on
// - limited step per interval in normal operation
// - done flag only after phases end
module accel_decimation_offset_cancel #(
    parameter int PH1_CYCLES = accel_dsp_pkg::PH1_CYC,
    parameter int PH2_CYCLES = accel_dsp_pkg::PH2_CYC,
    parameter int ST_CYCLES = accel_dsp_pkg::ST_SEQ_CYC,
    parameter int RATE_CYCLES = accel_dsp_pkg::RATE_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic SD_BIT,                      // modulator bit
    input wire logic SD_STROBE,                   // one pulse per bit
    input wire logic SELFTEST_RUN,                // self-test requested
    input wire logic SECOND_SELFTEST_STEP,        // second self-test step
    input wire logic NORMAL_OFFSET_FILTER_SELECT, // 0: 0.1 Hz, 1: 0.3 Hz
    output logic signed [25:0] ACCEL_OUT,         // offset-free sample
    output logic ACCEL_VALID,                     // pulse per new sample
    output logic signed [25:0] OFFSET_OUT,        // offset estimate
    output logic OFFSET_INIT_DONE_N               // low once init complete
);
    import accel_dsp_pkg::*;

    // ==================================================================
    // arithmetic helpers
    // product of a data word and a coefficient
    function automatic logic signed [59:0] cmul(input logic signed [25:0] d,
                                                input logic signed [31:0] c);
        // widen both operands first so the product keeps all its bits
        cmul = 60'(d) * 60'(c);
    endfunction : cmul

    // ==================================================================
    // sinc decimator
    logic [12:0] int1_reg, int2_reg, int3_reg;   // integrators, wrap on purpose
    logic [12:0] cd1_reg, cd2_reg, cd3_reg;      // comb delays
    logic [3:0] dec_cnt_reg;                     // position within block
    logic [12:0] cic_reg;                        // decimated value 0..4096
    logic cic_vld_reg;
    wire [12:0] comb1 = int3_reg - cd1_reg;
    wire [12:0] comb2 = comb1 - cd2_reg;
    wire [12:0] comb3 = comb2 - cd3_reg;
    wire dec_wrap = SD_STROBE && (dec_cnt_reg == 4'(DEC_LEN - 1));

    // integrate every bit, comb once per block of sixteen
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            int1_reg <= 13'h0000;
            int2_reg <= 13'h0000;
            int3_reg <= 13'h0000;
            cd1_reg <= 13'h0000;
            cd2_reg <= 13'h0000;
            cd3_reg <= 13'h0000;
            dec_cnt_reg <= 4'h0;
            cic_reg <= CIC_MID;
            cic_vld_reg <= 1'b0;
        end else begin
            cic_vld_reg <= dec_wrap;
            if (SD_STROBE) begin
                int1_reg <= int1_reg + {12'h000, SD_BIT};
                int2_reg <= int2_reg + int1_reg;
                int3_reg <= int3_reg + int2_reg;
                dec_cnt_reg <= dec_cnt_reg + 4'h1;
            end
            if (dec_wrap) begin
                cd1_reg <= int3_reg;
                cd2_reg <= comb1;
                cd3_reg <= comb2;
                cic_reg <= comb3;
            end
        end
    end

    // centre and scale: 4096 is full gain, centred on 2048 and shifted left by 8
    wire signed [13:0] cic_ctr = $signed({1'b0, cic_reg}) -
                                 $signed({1'b0, CIC_MID});
    wire signed [25:0] lp_in = 26'(cic_ctr) <<< CIC_SHIFT;

    // ==================================================================
    // low-pass: first-order section, second-order section, gain
    logic signed [25:0] s1_x1_reg, s1_y1_reg;    // section one history
    logic signed [25:0] s2_x1_reg, s2_x2_reg;    // section two inputs
    logic signed [25:0] s2_y1_reg, s2_y2_reg;    // section two outputs
    logic signed [25:0] lp_reg;                  // filtered sample
    logic s1_vld_reg, s2_vld_reg, lp_vld_reg;
    wire signed [59:0] s1_acc = cmul(lp_in, LP_N11) + cmul(s1_x1_reg, LP_N12)
                              - cmul(s1_y1_reg, LP_D12);
    wire signed [25:0] s1_y = s1_acc[LP_FRAC+25:LP_FRAC];
    wire signed [59:0] s2_acc = cmul(s1_y1_reg, LP_N21)
                              + cmul(s2_x1_reg, LP_N22)
                              + cmul(s2_x2_reg, LP_N23)
                              - cmul(s2_y1_reg, LP_D22)
                              - cmul(s2_y2_reg, LP_D23);
    wire signed [25:0] s2_y = s2_acc[LP_FRAC+25:LP_FRAC];
    wire signed [59:0] a0_acc = cmul(s2_y1_reg, LP_A0);

    // one section per cycle, stepped by the valid chain
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_x1_reg <= 26'sh0000000;
            s1_y1_reg <= 26'sh0000000;
            s2_x1_reg <= 26'sh0000000;
            s2_x2_reg <= 26'sh0000000;
            s2_y1_reg <= 26'sh0000000;
            s2_y2_reg <= 26'sh0000000;
            lp_reg <= 26'sh0000000;
            s1_vld_reg <= 1'b0;
            s2_vld_reg <= 1'b0;
            lp_vld_reg <= 1'b0;
        end else begin
            s1_vld_reg <= cic_vld_reg;
            s2_vld_reg <= s1_vld_reg;
            lp_vld_reg <= s2_vld_reg;
            if (cic_vld_reg) begin
                s1_x1_reg <= lp_in;
                s1_y1_reg <= s1_y;
            end
            if (s1_vld_reg) begin
                s2_x1_reg <= s1_y1_reg;
                s2_x2_reg <= s2_x1_reg;
                s2_y1_reg <= s2_y;
                s2_y2_reg <= s2_y1_reg;
            end
            if (s2_vld_reg) begin
                lp_reg <= a0_acc[LP_FRAC+25:LP_FRAC];
            end
        end
    end

    // ==================================================================
    // startup phase sequencer
    phase_e phase_reg, phase_next;
    logic [31:0] ph_cnt_reg;                     // cycles left in phase
    logic [31:0] ph_cnt_next;
    logic [2:0] st_rep_reg, st_rep_next;         // self-test sequences run
    wire ph_end = (ph_cnt_reg == 32'h00000000);

    // phase order after reset: fast, mid, optional self-test, done
    always_comb begin
        phase_next = phase_reg;
        ph_cnt_next = ph_end ? ph_cnt_reg : ph_cnt_reg - 32'h00000001;
        st_rep_next = st_rep_reg;
        case (phase_reg)
            PH_FAST: begin
                if (ph_end) begin
                    phase_next = PH_MID;
                    ph_cnt_next = 32'(PH2_CYCLES - 1);
                end
            end
            PH_MID: begin
                if (ph_end && SELFTEST_RUN) begin
                    phase_next = PH_SELFTEST;
                    ph_cnt_next = 32'(ST_CYCLES - 1);
                    st_rep_next = 3'h1;
                end else if (ph_end) begin
                    phase_next = PH_DONE;
                end
            end
            PH_SELFTEST: begin
                if (ph_end && SELFTEST_RUN &&
                    st_rep_reg < 3'(ST_MAX_REPEATS)) begin
                    ph_cnt_next = 32'(ST_CYCLES - 1);
                    st_rep_next = st_rep_reg + 3'h1;
                end else if (ph_end) begin
                    phase_next = PH_DONE;
                end
            end
            PH_DONE: begin
                phase_next = PH_DONE;
            end
            default: begin
                phase_next = PH_FAST;
            end
        endcase
    end

    // phase state, restarted by every reset
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_reg <= PH_FAST;
            ph_cnt_reg <= 32'(PH1_CYCLES - 1);
            st_rep_reg <= 3'h0;
        end else begin
            phase_reg <= phase_next;
            ph_cnt_reg <= ph_cnt_next;
            st_rep_reg <= st_rep_next;
        end
    end

    // ==================================================================
    // offset low-pass with phase dependent coefficients
    wire use_fast = (phase_reg == PH_FAST);
    wire use_mid = (phase_reg == PH_MID) || (phase_reg == PH_SELFTEST) ||
                   ((phase_reg == PH_DONE) && NORMAL_OFFSET_FILTER_SELECT);
    wire signed [31:0] of_a = use_fast ? OF10_A :
                              use_mid ? OF03_A : OF01_A;
    wire signed [31:0] of_n = use_fast ? OF10_N : use_mid ? OF03_N : OF01_N;
    wire signed [31:0] of_d = use_fast ? OF10_D : use_mid ? OF03_D : OF01_D;
    // self-test, or its second step before init is done, freezes the offset path
    wire frozen = (phase_reg == PH_SELFTEST) ||
                  (SECOND_SELFTEST_STEP && phase_reg != PH_DONE);
    wire limiting = (phase_reg == PH_DONE);
    logic signed [25:0] of_x1_reg, of_y1_reg;    // offset filter history
    logic [31:0] rate_cnt_reg;                   // cycles to next step
    logic hp_vld_reg;
    wire signed [59:0] of_num = cmul(lp_reg, of_n) + cmul(of_x1_reg, of_n);
    wire signed [25:0] of_numq = of_num[OF_FRAC+25:OF_FRAC];
    wire signed [59:0] of_acc = cmul(of_numq, of_a) - cmul(of_y1_reg, of_d);
    wire signed [25:0] of_y = of_acc[OF_FRAC+25:OF_FRAC];
    wire rate_tick = (rate_cnt_reg == 32'h00000000);
    wire signed [25:0] of_diff = of_y1_reg - OFFSET_OUT;
    wire signed [25:0] step_up = OFFSET_OUT + RATE_STEP;
    wire signed [25:0] step_dn = OFFSET_OUT - RATE_STEP;
    wire signed [25:0] limited = (of_diff > RATE_STEP) ? step_up :
                                 (of_diff < -RATE_STEP) ? step_dn :
                                 of_y1_reg;

    // offset filter update, offset output and offset-free sample
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            of_x1_reg <= 26'sh0000000;
            of_y1_reg <= 26'sh0000000;
            OFFSET_OUT <= 26'sh0000000;
            ACCEL_OUT <= 26'sh0000000;
            rate_cnt_reg <= 32'h00000000;
            hp_vld_reg <= 1'b0;
        end else begin
            hp_vld_reg <= lp_vld_reg;
            rate_cnt_reg <= (rate_tick || !limiting) ?
                            32'(RATE_CYCLES - 1) :
                            rate_cnt_reg - 32'h00000001;
            if (lp_vld_reg && !frozen) begin
                of_x1_reg <= lp_reg;
                of_y1_reg <= of_y;
            end
            if (limiting && rate_tick) begin
                OFFSET_OUT <= limited;
            end else if (!limiting && !frozen) begin
                OFFSET_OUT <= of_y1_reg;
            end
            if (lp_vld_reg) begin
                ACCEL_OUT <= lp_reg - OFFSET_OUT;
            end
        end
    end

    // ==================================================================
    // outputs
    assign ACCEL_VALID = hp_vld_reg;
    assign OFFSET_INIT_DONE_N = (phase_reg != PH_DONE);
endmodule : accel_decimation_offset_cancel

/* File: hw/accel_dsp_pkg.sv */
// constants of the acceleration decimation and offset cancellation path
package accel_dsp_pkg;
    // ==================================================================
    // timing
    localparam int CLK_HZ = 50_000_000;       // MCLK rate
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int PH1_MS = 80;               // 10 Hz startup phase
    localparam int PH2_MS = 70;               // 0.3 Hz startup phase
    localparam int ST_SEQ_MS = 96;            // one self-test sequence
    localparam int PH1_CYC = PH1_MS * CYC_PER_MS;
    localparam int PH2_CYC = PH2_MS * CYC_PER_MS;
    localparam int ST_SEQ_CYC = ST_SEQ_MS * CYC_PER_MS;
    localparam int ST_MAX_REPEATS = 6;        // most self-test sequences
    localparam int RATE_INTERVAL_US = 1024;   // rate limit update interval
    localparam int RATE_CYC = RATE_INTERVAL_US * (CLK_HZ / 1_000_000);
    localparam logic signed [25:0] RATE_STEP = 26'sh0000001; // lsb per step
    // ==================================================================
    // decimator
    localparam int DEC_LEN = 16;              // samples per output
    localparam logic [12:0] CIC_MID = 13'h0800; // half of full gain 4096
    localparam int CIC_SHIFT = 8;             // scaling into the data word
    // ==================================================================
    // low-pass, coefficients scaled by 2^24
    localparam int LP_FRAC = 24;
    localparam logic signed [31:0] LP_A0 = 32'sd870609;
    localparam logic signed [31:0] LP_N11 = 32'sd27331;
    localparam logic signed [31:0] LP_N12 = 32'sd27353;
    localparam logic signed [31:0] LP_D12 = -32'sd15906607;
    localparam logic signed [31:0] LP_N21 = 32'sd4195944;
    localparam logic signed [31:0] LP_N22 = 32'sd8388607;
    localparam logic signed [31:0] LP_N23 = 32'sd4192665;
    localparam logic signed [31:0] LP_D22 = -32'sd32142581;
    localparam logic signed [31:0] LP_D23 = 32'sd15420049;
    // ==================================================================
    // offset low-pass, coefficients scaled by 2^30
    localparam int OF_FRAC = 30;
    localparam logic signed [31:0] OF10_A = 32'sd17133632;
    localparam logic signed [31:0] OF10_N = 32'sd536868907;
    localparam logic signed [31:0] OF10_D = -32'sd1056608192;
    localparam logic signed [31:0] OF03_A = 32'sd517952;
    localparam logic signed [31:0] OF03_N = 32'sd536804574;
    localparam logic signed [31:0] OF03_D = -32'sd1073223872;
    localparam logic signed [31:0] OF01_A = 32'sd172672;
    localparam logic signed [31:0] OF01_N = 32'sd536870848;
    localparam logic signed [31:0] OF01_D = -32'sd1073569088;
    // ==================================================================
    // offset cancellation phases
    typedef enum logic [1:0] {PH_FAST, PH_MID, PH_SELFTEST, PH_DONE} phase_e;
endpackage : accel_dsp_pkg
